// ==== common/dram_mode_pkg.sv ====
// Constants, types and the write-recovery lookup for the mode register bank.
// Assumes one 25 MHz device clock; the link clock is sampled, not used as clock.
package dram_mode_pkg;

  // ****************************************************************
  // Addresses and field positions
  // ****************************************************************
  localparam logic [5:0] MA_CAPABILITY = 6'h00;
  localparam logic [5:0] MA_BURST = 6'h01;

  localparam int CAP_REFRESH_BIT = 0;
  localparam int CAP_LATENCY_BIT = 1;
  localparam int CAP_RSVD_LO_BIT = 2;
  localparam int CAP_SELFTEST_LSB = 3;
  localparam int CAP_SINGLE_BIT = 5;
  localparam int CAP_RSVD_HI_BIT = 6;
  localparam int CAP_CA_TERMINATION_FLAG_BIT = 7;

  localparam int BURST_LEN_LSB = 0;
  localparam int WR_PRE_BIT = 2;
  localparam int RD_PRE_BIT = 3;
  localparam int WR_REC_LSB = 4;
  localparam int RD_POST_BIT = 7;

  // ****************************************************************
  // Codes and reset values
  // ****************************************************************
  localparam logic [1:0] BL_16 = 2'h0;
  localparam logic [1:0] BL_32 = 2'h1;
  localparam logic [1:0] BL_OTF = 2'h2;

  localparam logic [1:0] ST_UNSUPPORTED = 2'h0;
  localparam logic [1:0] ST_GND_FLOAT = 2'h1;
  localparam logic [1:0] ST_VDDQ_SHORT = 2'h2;
  localparam logic [1:0] ST_PASS = 2'h3;

  localparam logic [1:0] LAT_TABLE_1 = 2'h1;
  localparam logic [7:0] BURST_RESET = 8'h04;
  localparam logic [7:0] MRR_UNMAPPED = 8'h00;

  // Write-recovery clocks, code 7 in the top seven bits
  localparam logic [55:0] WR_X16_T0 =
    {7'h28, 7'h22, 7'h1E, 7'h18, 7'h14, 7'h10, 7'h0A, 7'h06};
  localparam logic [55:0] WR_X8_T0 =
    {7'h2C, 7'h26, 7'h20, 7'h1C, 7'h16, 7'h10, 7'h0C, 7'h06};
  localparam logic [55:0] WR_X16_T1 =
    {7'h4B, 7'h42, 7'h38, 7'h2F, 7'h26, 7'h1D, 7'h13, 7'h0B};
  localparam logic [55:0] WR_X8_T1 =
    {7'h4F, 7'h44, 7'h3A, 7'h32, 7'h29, 7'h20, 7'h15, 7'h0B};
  localparam int WR_ENTRY_W = 7;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int CAL_LATCH_WAIT_NS = 30;
  localparam int CAL_LATCH_WAIT_CYC =
    (CAL_LATCH_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAIT_W = 8;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic ck;
    logic mrw;
    logic mrr;
    logic zq_start;
    logic zq_latch;
    logic rw;
    logic bl;
    logic zq_to_ground;
    logic zq_to_vddq;
    logic [5:0] ma;
    logic [7:0] op;
  } link_pins_t;

  typedef struct packed {
    logic only_modified_refresh;
    logic byte_latency;
    logic single_ended;
    logic ca_term_vendor;
  } straps_t;

  function automatic logic [6:0] wr_recovery_clocks(
    input logic [1:0] tbl,
    input logic byte_mode,
    input logic [2:0] code
  );
    logic [55:0] row;
    if (tbl == LAT_TABLE_1)
      row = byte_mode ? WR_X8_T1 : WR_X16_T1;
    else
      row = byte_mode ? WR_X8_T0 : WR_X16_T0;
    return row[code * WR_ENTRY_W +: WR_ENTRY_W];
  endfunction : wr_recovery_clocks

endpackage : dram_mode_pkg

// ==== rtl/sync2.sv ====
// Two-stage synchroniser, one per bit.
// Assumes inputs may change at any time relative to i_clk.
`timescale 1ns/1ns
module sync2 #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta;

  for (genvar b = 0; b < W; b++)
  begin : g_bit
    always_ff @(posedge i_clk)
    begin
      if (i_rst)
      begin
        meta[b] <= 1'b0;
        o_sync[b] <= 1'b0;
      end
      else
      begin
        meta[b] <= i_async[b];
        o_sync[b] <= meta[b];
      end
    end
  end
endmodule : sync2

// ==== rtl/setpoint_store.sv ====
// Two set-point copies of the burst/preamble/recovery register.
// Assumes writes and selects arrive on i_clk; both read ports are registered.
`timescale 1ns/1ns
module setpoint_store (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wr_en,
  input wire logic i_wr_sel,
  input wire logic [7:0] i_wr_data,
  input wire logic i_rd_sel,
  input wire logic i_op_sel,
  output logic [7:0] o_rd_data,
  output logic [7:0] o_op_data
);
  logic [7:0] copy [2];

  for (genvar s = 0; s < 2; s++)
  begin : g_copy
    always_ff @(posedge i_clk)
    begin
      if (i_rst)
        copy[s] <= dram_mode_pkg::BURST_RESET;
      else if (i_wr_en && (i_wr_sel == 1'(s)))
        copy[s] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_rd_data <= dram_mode_pkg::BURST_RESET;
      o_op_data <= dram_mode_pkg::BURST_RESET;
    end
    else
    begin
      o_rd_data <= copy[i_rd_sel];
      o_op_data <= copy[i_op_sel];
    end
  end
endmodule : setpoint_store

// ==== rtl/dram_mode_regs.sv ====
// Capability/status and burst/preamble/recovery mode registers of one die.
// Assumes link pins sampled by i_clk, straps static, set-point selects on i_clk.
//
// Behaviour
// - Bit 0 reports refresh scheme support
// - Bit 1 reports normal or byte latency
// - Self-test field encodes four result codes
// - Self-test valid after start, latch, wait
// - Grounded calibration pin reports code 01
// - Assembly error: factory trim, ignore calibration
// - Bit 5 reports single-ended support
// - Bit 7 reports command/address termination
// - Burst field selects 16, 32, per-command
// - Per-command mode takes burst from command
// - Write preamble bit one means two clocks
// - Read preamble bit selects static or toggling
// - x16 table 0 recovery codes map
// - Byte table 0 recovery codes map
// - Table 1 recovery codes map
// - Count recovery clocks, then start precharge
// - Read postamble bit selects half or 1.5
// - Two copies; read returns write-selected copy
// - Operate only from operating-selected copy
`timescale 1ns/1ns
module dram_mode_regs #(
  parameter bit SELFTEST_SUPPORTED = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire dram_mode_pkg::link_pins_t i_link,
  input wire dram_mode_pkg::straps_t i_straps,
  input wire logic i_write_setpoint_sel,
  input wire logic i_operating_setpoint_sel,
  input wire logic [1:0] i_latency_table_sel,
  input wire logic i_byte_mode,
  input wire logic i_wr_ap_burst_end,
  output logic [7:0] o_mrr_data,
  output logic o_mrr_valid,
  output logic o_burst_valid,
  output logic o_burst_len_32,
  output logic o_wr_preamble_2ck,
  output logic o_rd_preamble_toggle,
  output logic o_rd_postamble_long,
  output logic o_precharge_start,
  output logic o_cal_start,
  output logic o_cal_latch,
  output logic o_factory_trim,
  output logic o_selftest_valid
);

  // ****************************************************************
  // Link sampling
  // ****************************************************************
  dram_mode_pkg::link_pins_t link_s;
  dram_mode_pkg::straps_t straps_r;
  logic ck_prev;

  sync2 #(
    .W($bits(dram_mode_pkg::link_pins_t))
  ) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async(i_link),
    .o_sync(link_s)
  );

  // Strap pins come from outside the clock domain as well
  sync2 #(
    .W($bits(dram_mode_pkg::straps_t))
  ) u_strap_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async(i_straps),
    .o_sync(straps_r)
  );

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      ck_prev <= 1'b0;
    else
      ck_prev <= link_s.ck;
  end

  wire ck_rise = link_s.ck & ~ck_prev;
  wire mrw_take = ck_rise & link_s.mrw;
  wire mrr_take = ck_rise & link_s.mrr;
  wire rw_take = ck_rise & link_s.rw;
  wire zq_start_seen = ck_rise & link_s.zq_start;
  wire zq_latch_seen = ck_rise & link_s.zq_latch;
  wire ma_cap = (link_s.ma == dram_mode_pkg::MA_CAPABILITY);
  wire ma_burst = (link_s.ma == dram_mode_pkg::MA_BURST);

  // ****************************************************************
  // Set-point copies
  // ****************************************************************
  logic [7:0] rd_copy;
  logic [7:0] op_copy;
  wire burst_wr_en = mrw_take & ma_burst;

  setpoint_store u_store (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_wr_en(burst_wr_en),
    .i_wr_sel(i_write_setpoint_sel),
    .i_wr_data(link_s.op),
    .i_rd_sel(i_write_setpoint_sel),
    .i_op_sel(i_operating_setpoint_sel),
    .o_rd_data(rd_copy),
    .o_op_data(op_copy)
  );

  // ****************************************************************
  // Calibration self-test
  // ****************************************************************
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_STARTED = 4'h2,
    S_WAIT = 4'h4,
    S_DONE = 4'h8
  } cal_state_t;

  cal_state_t cal_state;
  cal_state_t next_cal_state;
  logic [dram_mode_pkg::WAIT_W-1:0] wait_cnt;
  logic [1:0] selftest;

  wire zq_start_take = zq_start_seen & ~o_factory_trim;
  wire zq_latch_take = zq_latch_seen & ~o_factory_trim;
  wire wait_over = (wait_cnt == dram_mode_pkg::WAIT_W'(
    dram_mode_pkg::CAL_LATCH_WAIT_CYC - 1));
  wire cal_finish = (cal_state == S_WAIT) & wait_over;
  wire [1:0] pin_result = link_s.zq_to_ground ? dram_mode_pkg::ST_GND_FLOAT :
                          link_s.zq_to_vddq ? dram_mode_pkg::ST_VDDQ_SHORT :
                          dram_mode_pkg::ST_PASS;
  wire [1:0] next_selftest = SELFTEST_SUPPORTED ? pin_result :
                             dram_mode_pkg::ST_UNSUPPORTED;
  wire result_error = (next_selftest == dram_mode_pkg::ST_GND_FLOAT) |
                      (next_selftest == dram_mode_pkg::ST_VDDQ_SHORT);

  always_comb
  begin
    next_cal_state = cal_state;
    case (cal_state)
      S_IDLE, S_DONE:
        if (zq_start_take)
          next_cal_state = S_STARTED;
      S_STARTED:
        if (zq_latch_take)
          next_cal_state = S_WAIT;
      S_WAIT:
        if (wait_over)
          next_cal_state = S_DONE;
      default:
        next_cal_state = S_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cal_state <= S_IDLE;
      wait_cnt <= '0;
      selftest <= dram_mode_pkg::ST_UNSUPPORTED;
      o_selftest_valid <= 1'b0;
      o_factory_trim <= 1'b0;
      o_cal_start <= 1'b0;
      o_cal_latch <= 1'b0;
    end
    else
    begin
      cal_state <= next_cal_state;
      wait_cnt <= (cal_state == S_WAIT) ? wait_cnt + 1'b1 : '0;
      o_cal_start <= zq_start_take;
      o_cal_latch <= zq_latch_take;
      if (cal_finish)
      begin
        selftest <= next_selftest;
        o_selftest_valid <= 1'b1;
        o_factory_trim <= result_error;
      end
    end
  end

  // ****************************************************************
  // Capability value and mode register read
  // ****************************************************************
  wire [7:0] cap_value;
  assign cap_value[dram_mode_pkg::CAP_REFRESH_BIT] =
    straps_r.only_modified_refresh;
  assign cap_value[dram_mode_pkg::CAP_LATENCY_BIT] =
    straps_r.byte_latency;
  assign cap_value[dram_mode_pkg::CAP_RSVD_LO_BIT] = 1'b0;
  assign cap_value[dram_mode_pkg::CAP_SELFTEST_LSB +: 2] = selftest;
  assign cap_value[dram_mode_pkg::CAP_SINGLE_BIT] =
    straps_r.single_ended;
  assign cap_value[dram_mode_pkg::CAP_RSVD_HI_BIT] = 1'b0;
  assign cap_value[dram_mode_pkg::CAP_CA_TERMINATION_FLAG_BIT] =
    straps_r.ca_term_vendor;

  wire [7:0] mrr_value = ma_cap ? cap_value :
                         ma_burst ? rd_copy :
                         dram_mode_pkg::MRR_UNMAPPED;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_mrr_data <= dram_mode_pkg::MRR_UNMAPPED;
      o_mrr_valid <= 1'b0;
    end
    else
    begin
      o_mrr_valid <= mrr_take;
      if (mrr_take)
        o_mrr_data <= mrr_value;
    end
  end

  // ****************************************************************
  // Operating settings from the active copy
  // ****************************************************************
  wire [1:0] bl_active = op_copy[dram_mode_pkg::BURST_LEN_LSB +: 2];
  wire next_len_32 = (bl_active == dram_mode_pkg::BL_32) |
                     ((bl_active == dram_mode_pkg::BL_OTF) & link_s.bl);

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_burst_valid <= 1'b0;
      o_burst_len_32 <= 1'b0;
      o_wr_preamble_2ck <=
        dram_mode_pkg::BURST_RESET[dram_mode_pkg::WR_PRE_BIT];
      o_rd_preamble_toggle <=
        dram_mode_pkg::BURST_RESET[dram_mode_pkg::RD_PRE_BIT];
      o_rd_postamble_long <=
        dram_mode_pkg::BURST_RESET[dram_mode_pkg::RD_POST_BIT];
    end
    else
    begin
      o_burst_valid <= rw_take;
      if (rw_take)
        o_burst_len_32 <= next_len_32;
      o_wr_preamble_2ck <= op_copy[dram_mode_pkg::WR_PRE_BIT];
      o_rd_preamble_toggle <= op_copy[dram_mode_pkg::RD_PRE_BIT];
      o_rd_postamble_long <= op_copy[dram_mode_pkg::RD_POST_BIT];
    end
  end

  // ****************************************************************
  // Write recovery before auto-precharge
  // ****************************************************************
  logic [6:0] wr_left;
  wire [6:0] wr_target = dram_mode_pkg::wr_recovery_clocks(
    i_latency_table_sel, i_byte_mode,
    op_copy[dram_mode_pkg::WR_REC_LSB +: 3]);
  wire wr_last = (wr_left == 7'h01) & ck_rise;
  wire [6:0] next_wr_left = i_wr_ap_burst_end ? wr_target :
                            (ck_rise && wr_left != 7'h00) ?
                            wr_left - 7'h01 : wr_left;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      wr_left <= 7'h00;
      o_precharge_start <= 1'b0;
    end
    else
    begin
      wr_left <= next_wr_left;
      o_precharge_start <= wr_last & ~i_wr_ap_burst_end;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [5:0] mrr_ma_q;
  logic [6:0] wr_goal_q;
  logic [6:0] wr_edges;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      mrr_ma_q <= 6'h00;
      wr_goal_q <= 7'h00;
      wr_edges <= 7'h00;
    end
    else
    begin
      if (mrr_take)
        mrr_ma_q <= link_s.ma;
      if (i_wr_ap_burst_end)
      begin
        wr_goal_q <= wr_target;
        wr_edges <= 7'h00;
      end
      else if (ck_rise)
        wr_edges <= wr_edges + 7'h01;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  a_cap_reserved_zero: assert property (
    o_mrr_valid && mrr_ma_q == dram_mode_pkg::MA_CAPABILITY |->
    !o_mrr_data[dram_mode_pkg::CAP_RSVD_LO_BIT] &&
    !o_mrr_data[dram_mode_pkg::CAP_RSVD_HI_BIT])
    else $error("reserved capability bit read as one");

  a_cap_refresh_bit: assert property (
    mrr_take && ma_cap |=>
    o_mrr_data[dram_mode_pkg::CAP_REFRESH_BIT] ==
    $past(straps_r.only_modified_refresh))
    else $error("refresh support bit wrong");

  a_selftest_after_latch: assert property (
    $rose(o_selftest_valid) |->
    $past(cal_state == S_WAIT) && $past(wait_over))
    else $error("self-test valid without latch wait");

  a_selftest_ground: assert property (
    cal_finish && link_s.zq_to_ground && SELFTEST_SUPPORTED |=>
    selftest == dram_mode_pkg::ST_GND_FLOAT && o_factory_trim)
    else $error("grounded pin not reported as 01");

  a_cal_ignored_trim: assert property (
    o_factory_trim && zq_start_seen |=> !o_cal_start ##0
    $stable(cal_state))
    else $error("calibration command taken after assembly error");

  a_otf_burst_choice: assert property (
    rw_take && bl_active == dram_mode_pkg::BL_OTF |=>
    o_burst_valid && o_burst_len_32 == $past(link_s.bl))
    else $error("per-command burst length not honoured");

  a_precharge_delay: assert property (
    o_precharge_start |-> wr_edges == wr_goal_q && wr_goal_q != 7'h00)
    else $error("precharge started at wrong clock count");

  a_read_copy_sel: assert property (
    mrr_take && ma_burst && $stable(i_write_setpoint_sel) |=>
    o_mrr_data == $past(rd_copy))
    else $error("read returned the wrong set-point copy");

  a_cap_write_ignored: assert property (
    mrw_take && ma_cap |=> $stable(cap_value) [*2])
    else $error("write changed capability register");

endmodule : dram_mode_regs

// ==== verification/ctl_model.sv ====
// Behavioural controller that drives the link command pins of the bank.
// Assumes i_clk is the device clock; the bench calls the tasks below.
`timescale 1ns/1ns
module ctl_model (
  input wire logic i_clk,
  output dram_mode_pkg::link_pins_t o_link
);
  // ****************************************************************
  // Command frames
  // ****************************************************************
  initial o_link = '0;

  // Link clock stands low between frames; pins held 4 clk around the rise
  task automatic frame(input logic [4:0] cmd, input logic bl,
                       input logic [5:0] ma, input logic [7:0] op);
    @(negedge i_clk);
    {o_link.mrw, o_link.mrr, o_link.zq_start} = cmd[4:2];
    {o_link.zq_latch, o_link.rw} = cmd[1:0];
    o_link.bl = bl;
    o_link.ma = ma;
    o_link.op = (cmd[4] && ma == 6'h01) ? (op | 8'h04) : op;
    repeat (4) @(negedge i_clk);
    o_link.ck = 1'b1;
    repeat (4) @(negedge i_clk);
    o_link.ck = 1'b0;
    {o_link.mrw, o_link.mrr, o_link.zq_start} = 3'h0;
    {o_link.zq_latch, o_link.rw} = 2'h0;
    o_link.bl = ~bl;
    o_link.ma = ~ma;
    o_link.op = ~op;
  endtask : frame

  // Idle frames give link clock rises with no command
  task automatic tick(input int n);
    repeat (n) frame(5'h00, o_link.bl, o_link.ma, o_link.op);
  endtask : tick

  task automatic zq_pins(input logic g, input logic v);
    @(negedge i_clk);
    o_link.zq_to_ground = g;
    o_link.zq_to_vddq = v;
  endtask : zq_pins
endmodule : ctl_model

// ==== verification/dram_mode_regs_tb_top.sv ====
// Self-checking bench for the mode register bank.
// Assumes the controller model drives the link; other inputs come from here.
`timescale 1ns/1ns
module dram_mode_regs_tb_top;
  localparam logic [4:0] C_MRW = 5'h10;
  localparam logic [4:0] C_MRR = 5'h08;
  localparam logic [4:0] C_ZQS = 5'h04;
  localparam logic [4:0] C_ZQL = 5'h02;
  localparam logic [4:0] C_RW = 5'h01;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  dram_mode_pkg::link_pins_t link;
  dram_mode_pkg::straps_t straps = '0;
  logic wsel = 1'b0;
  logic osel = 1'b0;
  logic [1:0] tsel = 2'h0;
  logic bmode = 1'b0;
  logic ap_end = 1'b0;
  logic [7:0] mrr_data;
  logic mrr_valid, burst_valid, len32, wpre, rpre, rpost, pc_start;
  logic cal_start, cal_latch, ftrim, st_valid;
  logic [7:0] rd_val = 8'h00;
  logic bl_seen = 1'b0;
  int rd_cnt = 0;
  int pc_cnt = 0;
  int cs_cnt = 0;
  int cl_cnt = 0;
  int bv_cnt = 0;
  int n0;
  int n_mismatch = 0;
  int cmp_count = 0;
  int r_tbl[7] = '{0, 0, 0, 0, 1, 1, 1};
  int r_bm[7] = '{0, 0, 0, 1, 0, 0, 1};
  int r_code[7] = '{0, 3, 7, 7, 0, 7, 7};
  int r_n[7] = '{6, 20, 40, 44, 11, 75, 79};
  logic [1:0] st_exp[3] = '{2'h3, 2'h1, 2'h2};

  always #20 i_clk = ~i_clk;
  always @(posedge i_clk) if (mrr_valid === 1'b1) rd_val <= mrr_data;
  always @(posedge i_clk) if (mrr_valid === 1'b1) rd_cnt <= rd_cnt + 1;
  always @(posedge i_clk) if (burst_valid === 1'b1) bl_seen <= len32;
  always @(posedge i_clk) if (pc_start === 1'b1) pc_cnt <= pc_cnt + 1;
  always @(posedge i_clk) if (cal_start === 1'b1) cs_cnt <= cs_cnt + 1;
  always @(posedge i_clk) if (cal_latch === 1'b1) cl_cnt <= cl_cnt + 1;
  always @(posedge i_clk) if (burst_valid === 1'b1) bv_cnt <= bv_cnt + 1;

  ctl_model u_ctl (.i_clk(i_clk), .o_link(link));

  dram_mode_regs dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_link(link), .i_straps(straps),
    .i_write_setpoint_sel(wsel), .i_operating_setpoint_sel(osel),
    .i_latency_table_sel(tsel), .i_byte_mode(bmode),
    .i_wr_ap_burst_end(ap_end), .o_mrr_data(mrr_data),
    .o_mrr_valid(mrr_valid), .o_burst_valid(burst_valid),
    .o_burst_len_32(len32), .o_wr_preamble_2ck(wpre),
    .o_rd_preamble_toggle(rpre), .o_rd_postamble_long(rpost),
    .o_precharge_start(pc_start), .o_cal_start(cal_start),
    .o_cal_latch(cal_latch), .o_factory_trim(ftrim),
    .o_selftest_valid(st_valid)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic settle();
    repeat (4) @(negedge i_clk);
  endtask : settle

  task automatic do_reset();
    @(negedge i_clk);
    i_rst = 1'b1;
    repeat (5) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (3) @(negedge i_clk);
  endtask : do_reset

  task automatic wr(input logic [5:0] ma, input logic [7:0] op);
    u_ctl.frame(C_MRW, 1'b0, ma, op);
    settle();
  endtask : wr

  task automatic rd(input logic [5:0] ma, input logic [7:0] exp);
    int c0;
    c0 = rd_cnt;
    u_ctl.frame(C_MRR, 1'b0, ma, 8'h00);
    settle();
    check(8'(rd_cnt - c0), 8'h01);
    check(rd_val, exp);
  endtask : rd

  task automatic test_done();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  initial
  begin
    #400000;
    n_mismatch++;
    test_done();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    do_reset();
    check(wpre, 1'b1);
    check(len32, 1'b0);
    check(st_valid, 1'b0);
    rd(dram_mode_pkg::MA_BURST, dram_mode_pkg::BURST_RESET);
    rd(6'h05, dram_mode_pkg::MRR_UNMAPPED);
    for (int k = 0; k < 16; k++)
    begin
      straps = dram_mode_pkg::straps_t'(k[3:0]);
      if (k == 5)
        wr(dram_mode_pkg::MA_CAPABILITY, 8'hFF);
      rd(dram_mode_pkg::MA_CAPABILITY, {straps.ca_term_vendor, 1'b0,
         straps.single_ended, 3'h0, straps.byte_latency,
         straps.only_modified_refresh});
    end
    straps = '0;
    for (int s = 0; s < 3; s++)
    begin
      do_reset();
      u_ctl.zq_pins(s == 1, s == 2);
      u_ctl.frame(C_ZQS, 1'b0, 6'h00, 8'h00);
      rd(dram_mode_pkg::MA_CAPABILITY, 8'h00);
      n0 = cl_cnt;
      u_ctl.frame(C_ZQL, 1'b0, 6'h00, 8'h00);
      settle();
      check(8'(cl_cnt - n0), 8'h01);
      check(st_valid, 1'b1);
      rd(dram_mode_pkg::MA_CAPABILITY, {3'h0, st_exp[s], 3'h0});
      check(ftrim, s != 0);
      n0 = cs_cnt;
      u_ctl.frame(C_ZQS, 1'b0, 6'h00, 8'h00);
      settle();
      check(8'(cs_cnt - n0), s == 0);
    end
    do_reset();
    rd(dram_mode_pkg::MA_CAPABILITY, 8'h00);
    u_ctl.zq_pins(1'b0, 1'b0);
    wr(dram_mode_pkg::MA_BURST, 8'h84);
    wsel = 1'b1;
    wr(dram_mode_pkg::MA_BURST, 8'h3C);
    check(rpost, 1'b1);
    check(rpre, 1'b0);
    rd(dram_mode_pkg::MA_BURST, 8'h3C);
    wsel = 1'b0;
    rd(dram_mode_pkg::MA_BURST, 8'h84);
    osel = 1'b1;
    settle();
    check(rpost, 1'b0);
    check(rpre, 1'b1);
    osel = 1'b0;
    for (int c = 0; c < 4; c++)
      for (int b = 0; b < 2; b++)
      begin
        wsel = 1'b1;
        wr(dram_mode_pkg::MA_BURST, 8'h04 | 8'(c));
        wsel = 1'b0;
        wr(dram_mode_pkg::MA_BURST, 8'h04 | 8'(c));
        n0 = bv_cnt;
        u_ctl.frame(C_RW, b[0], 6'h00, 8'h00);
        settle();
        check(8'(bv_cnt - n0), 8'h01);
        check(bl_seen, (c == 1) || (c == 2 && b == 1));
      end
    wsel = 1'b1;
    wr(dram_mode_pkg::MA_BURST, 8'h04);
    wsel = 1'b0;
    for (int r = 0; r < 7; r++)
    begin
      tsel = 2'(r_tbl[r]);
      bmode = r_bm[r][0];
      wr(dram_mode_pkg::MA_BURST, {1'b0, 3'(r_code[r]), 4'h4});
      @(negedge i_clk);
      ap_end = 1'b1;
      @(negedge i_clk);
      ap_end = 1'b0;
      n0 = pc_cnt;
      u_ctl.tick(r_n[r] - 1);
      check(8'(pc_cnt - n0), 8'h00);
      u_ctl.tick(1);
      settle();
      check(8'(pc_cnt - n0), 8'h01);
    end
    test_done();
  end
endmodule : dram_mode_regs_tb_top
